// >>> testbench.sv
// Self-checking bench for the type A timer base counter, driven over AHB-Lite and the event tick input.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import timer_type_a_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, event_in;
    logic [31:0] haddr, hwdata, hrdata, rd_val;
    logic [1:0]  htrans;
    logic        hreadyout, hresp, ovf, ovf_hi;
    logic [2:0]  cmp_ev, cmp_hi, wave;
    logic        w0;
    logic [2:0]  w3;
    logic [15:0] p, q, c;
    int          n_fail, cmp_count, n_ovf, n_cmp, n_ohi, n_chi, o0, m0, cyc, seed;

    timer_type_a dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .event_in(event_in), .overflow_event(ovf),
        .overflow_hi_event(ovf_hi), .compare_event(cmp_ev), .compare_hi_event(cmp_hi), .waveform_output(wave));

    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // The ready level is sampled mid-cycle so the decision never races the edge's own updates.
    task automatic wait_rdy(output logic [31:0] d);
        logic r;
        do begin
            @(negedge hclk);
            r = hreadyout;
            d = hrdata;
            @(posedge hclk);
        end while (r !== 1'b1);
    endtask : wait_rdy

    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_rdy(d);
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(d);
        hsel   <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic [31:0] d;
        xfer(a, 1'b1, v, d);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 32'h00000000, rd_val);
    endtask : rd

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Enable stands for 1103 cycles: the 1100 waited plus the three-cycle disable write.
    function automatic logic [31:0] presc_exp(input int s);
        int n;
        n = (s < 5) ? (1 << s) : (16 << (2 * (s - 4)));
        return 32'h00008000 - 32'(1103 / n);
    endfunction : presc_exp

    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge hclk) event_in <= 1'b1;
            @(posedge hclk) event_in <= 1'b0;
            repeat (2) @(posedge hclk);
        end
    endtask : pulse

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : wrap_up

    always @(posedge hclk) begin
        cyc++;
        if (ovf === 1'b1) n_ovf++;
        if (cmp_ev[0] === 1'b1) n_cmp++;
        if (ovf_hi === 1'b1) n_ohi++;
        if (cmp_hi[1] === 1'b1) n_chi++;
        if (cyc > 30000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        {hresetn, hsel, hwrite, event_in, htrans, haddr, hwdata} = '0;
        {n_fail, cmp_count, n_ovf, n_cmp, n_ohi, n_chi, cyc} = '0;
        seed = 41;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(OFS_PERIOD);    chk(rd_val, 32'h0000ffff);
        rd(OFS_COUNT_VALUE); chk(rd_val, 32'h00000000);
        p = 16'h0010 | 16'($random(seed));
        q = 16'h0010 | 16'($random(seed));
        c = 16'($random(seed));
        wr(OFS_COUNT_VALUE, {16'h0000, c});
        repeat (10) @(posedge hclk);
        rd(OFS_COUNT_VALUE); chk(rd_val, {16'h0000, c});
        wr(OFS_PERIOD, {16'h0000, p});
        rd(OFS_PERIOD);    chk(rd_val, {16'h0000, p});
        wr(OFS_COMPARE_BASE, {16'h0000, p - 16'h0001});
        wr(OFS_COUNT_VALUE, {16'h0000, p - 16'h0002});
        wr(OFS_EVENT_CONTROL, 32'h00000001);
        wr(OFS_CONTROL_REG_A, 32'h00000001);
        w0 = wave[0];
        o0 = n_ovf;
        m0 = n_cmp;
        pulse(3);
        rd(OFS_COUNT_VALUE); chk(rd_val, 32'h00000000);
        chk(32'(n_ovf - o0), 32'h1);
        chk(32'(n_cmp - m0), 32'h1);
        chk({31'h0, wave[0]}, {31'h0, ~w0});
        wr(OFS_CONTROL_REG_E, 32'h00000001);
        wr(OFS_COUNT_VALUE, 32'h00000001);
        pulse(2);
        rd(OFS_COUNT_VALUE); chk(rd_val, {16'h0000, p});
        wr(OFS_CYCLE_SHADOW, {16'h0000, q});
        rd(OFS_CONTROL_REG_F); chk(rd_val, 32'h00000001);
        wr(OFS_CONTROL_REG_E, 32'h00000003);
        pulse(1);
        rd(OFS_PERIOD);    chk(rd_val, {16'h0000, p});
        wr(OFS_CONTROL_REG_E, 32'h00000001);
        wr(OFS_COUNT_VALUE, {16'h0000, p});
        pulse(1);
        rd(OFS_PERIOD);    chk(rd_val, {16'h0000, q});
        rd(OFS_CONTROL_REG_F); chk(rd_val, 32'h00000000);
        rd(OFS_COUNT_VALUE); chk(rd_val, {16'h0000, p - 16'h0001});
        wr(OFS_COMPARE_SHADOW, {16'h0000, c});
        rd(OFS_CONTROL_REG_F); chk(rd_val, 32'h00000002);
        rd(OFS_COMPARE_BASE); chk(rd_val, {16'h0000, p - 16'h0001});
        wr(OFS_COMPARE_BASE, {16'h0000, q});
        rd(OFS_COMPARE_BASE); chk(rd_val, {16'h0000, q});
        rd(8'hfc);         chk(rd_val, 32'h00000000);
        wr(OFS_COUNT_VALUE, {16'h0000, q});
        m0 = n_cmp;
        pulse(1);
        rd(OFS_COMPARE_BASE); chk(rd_val, {16'h0000, c});
        rd(OFS_CONTROL_REG_F); chk(rd_val, 32'h00000000);
        wr(OFS_COUNT_VALUE, {16'h0000, c});
        pulse(1);
        chk(32'(n_cmp - m0), 32'h2);
        // Split mode: low byte starts at zero, high byte at one; compare 0 matches only the low byte.
        wr(OFS_COMPARE_BASE, 32'h00000300);
        wr(OFS_CONTROL_REG_D, 32'h00000001);
        wr(OFS_COUNT_VALUE, 32'h00000100);
        wr(OFS_FLAGS, 32'h000000ff);
        w3 = wave;
        o0 = n_ohi;
        m0 = n_chi;
        pulse(2);
        rd(OFS_COUNT_VALUE); chk(rd_val, {16'h0000, q[15:8], q[7:0] - 8'h01});
        rd(OFS_FLAGS);     chk(rd_val, 32'h000000df);
        chk({29'h0, wave}, {29'h0, ~w3});
        chk(32'(n_ohi - o0), 32'h1);
        chk(32'(n_chi - m0), 32'h1);
        wr(OFS_COUNT_VALUE, 32'h0000ffff);
        rd(OFS_FLAGS);     chk(rd_val, 32'h000004df | ((q == 16'hffff) ? 32'h00000200 : 32'h0));
        wr(OFS_CONTROL_REG_A, 32'h00000000);
        wr(OFS_CONTROL_REG_D, 32'h00000000);
        wr(OFS_EVENT_CONTROL, 32'h00000000);
        for (int s = 0; s < 8; s++) begin
            wr(OFS_COUNT_VALUE, 32'h00008000);
            wr(OFS_CONTROL_REG_A, 32'(1 | (s << A_PRESCALE_LSB)));
            repeat (1100) @(posedge hclk);
            wr(OFS_CONTROL_REG_A, 32'h00000000);
            rd(OFS_COUNT_VALUE); chk(rd_val, presc_exp(s));
        end
        wrap_up();
    end
endmodule : testbench
`default_nettype wire

// >>> tick_prescaler.sv
// Divider that turns the peripheral clock into prescaled counting ticks.
`timescale 1ns/1ps
`default_nettype none
module tick_prescaler
    import timer_type_a_pkg::*;
(
    // Clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // Control
    input  wire logic       run,
    input  wire logic [2:0] select,
    // Tick out
    output logic            tick
);
    logic [PRESCALE_W-1:0] div_q;
    logic [PRESCALE_W-1:0] mask;

    assign mask = PRESCALE_MASK[select];

    // The divider restarts while stopped so the first tick after enable comes a full period later.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q <= '0;
        end else if (!run) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign tick = run && ((div_q & mask) == mask);
endmodule : tick_prescaler
`default_nettype wire

// >>> timer_type_a.sv
// Base counter of the 16-bit type A timer with double-buffered period and compares, on an AHB-Lite slave.
// What this block does
// - Counter, period, compares and shadows are 16-bit.
// - Detect BOTTOM at zero, MAX, TOP at period.
// - Counting up, TOP wraps to zero next tick.
// - Counting down, BOTTOM reloads period value.
// - Counter write is immediate and wins priority.
// - Direction may change while running.
// - Enable starts counting prescaled clock ticks.
// - Event tick enable counts events instead.
// - Compare counter with zero, period, compares.
// - Triggers appear on the following timer tick.
// - Tick source is prescaler or event input.
// - UPDATE copies valid shadows unless held or in split mode.
// - One shadow valid flag per shadow.
// - Shadow write sets flag, UPDATE clears it.
// - Compare and shadow both directly writable.
// - Split mode gives two 8-bit counters.
// - Compare match sets flag on next tick.
// - Transferred compare used from next count.
// - Unbuffered period write takes effect immediately.
`timescale 1ns/1ps
`default_nettype none
module timer_type_a
    import timer_type_a_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int NCH   = 3
)(
    // AHB-Lite clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // AHB-Lite slave
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic             hready,
    input  wire logic [31:0]      hwdata,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    // Event system
    input  wire logic             event_in,
    output logic                  overflow_event,
    output logic                  overflow_hi_event,
    output logic [NCH-1:0]        compare_event,
    output logic [NCH-1:0]        compare_hi_event,
    // Waveform pins
    output logic [NCH-1:0]        waveform_output
);
    localparam int HALF = CNT_W / 2;

    // Bus data phase state.
    logic                 dp_valid_q;
    logic                 dp_write_q;
    logic [7:0]           dp_addr_q;
    logic                 rd_ready_q;
    logic [31:0]          hrdata_q;
    logic [31:0]          rd_val;

    // Control fields.
    logic                 enable_q;
    logic [2:0]           presc_q;
    logic                 dir_q;
    logic                 hold_q;
    logic                 upd_bottom_q;
    logic                 evt_en_q;
    logic                 split_q;

    // Counter state.
    logic [CNT_W-1:0]     cnt_q;
    logic [CNT_W-1:0]     cnt_d;
    logic [CNT_W-1:0]     per_q;
    logic [CNT_W-1:0]     per_shadow_q;
    logic                 per_bv_q;
    logic [CNT_W-1:0]     cmp_q    [NCH];
    logic [CNT_W-1:0]     cmp_sh_q [NCH];
    logic [NCH-1:0]       cmp_bv_q;
    logic [NCH-1:0]       match_lo;
    logic [NCH-1:0]       match_hi;
    logic [NCH-1:0]       wr_cmp;
    logic [NCH-1:0]       wr_cmp_sh;
    logic [FLAG_W-1:0]    flags_q;
    logic [FLAG_W-1:0]    flag_set;

    logic                 pre_tick;
    logic                 tick;
    logic                 at_top;
    logic                 at_bottom;
    logic                 at_max;
    logic                 upd;
    logic                 ovf_now;
    logic                 ovf_hi_now;

    // Write strobes, valid in the single write data phase cycle.
    logic                 wr;
    logic                 wr_a;
    logic                 wr_e;
    logic                 wr_f;
    logic                 wr_ev;
    logic                 wr_d;
    logic                 wr_flags;
    logic                 wr_cnt;
    logic                 wr_per;
    logic                 wr_per_sh;

    assign wr        = dp_valid_q && dp_write_q;
    assign wr_a      = wr && (dp_addr_q == OFS_CONTROL_REG_A);
    assign wr_e      = wr && (dp_addr_q == OFS_CONTROL_REG_E);
    assign wr_f      = wr && (dp_addr_q == OFS_CONTROL_REG_F);
    assign wr_ev     = wr && (dp_addr_q == OFS_EVENT_CONTROL);
    assign wr_d      = wr && (dp_addr_q == OFS_CONTROL_REG_D);
    assign wr_flags  = wr && (dp_addr_q == OFS_FLAGS);
    assign wr_cnt    = wr && (dp_addr_q == OFS_COUNT_VALUE);
    assign wr_per    = wr && (dp_addr_q == OFS_PERIOD);
    assign wr_per_sh = wr && (dp_addr_q == OFS_CYCLE_SHADOW);

    // Reads take one wait state so a read right after a write sees the written value.
    assign hreadyout = !(dp_valid_q && !dp_write_q && !rd_ready_q);
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q  <= 8'h00;
        end else if (hreadyout) begin
            dp_valid_q <= hsel && htrans[1] && hready;
            dp_write_q <= hwrite;
            dp_addr_q  <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ready_q <= 1'b0;
            hrdata_q   <= 32'h0000_0000;
        end else if (dp_valid_q && !dp_write_q && !rd_ready_q) begin
            rd_ready_q <= 1'b1;
            hrdata_q   <= rd_val;
        end else begin
            rd_ready_q <= 1'b0;
        end
    end

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_val = 32'h0000_0000;
        if (dp_addr_q == OFS_CONTROL_REG_A) begin
            rd_val[A_ENABLE_BIT] = enable_q;
            rd_val[A_PRESCALE_LSB +: 3] = presc_q;
        end else if (dp_addr_q == OFS_CONTROL_REG_E) begin
            rd_val[E_DIR_BIT] = dir_q;
            rd_val[E_HOLD_BIT] = hold_q;
            rd_val[E_UPD_BOTTOM_BIT] = upd_bottom_q;
        end else if (dp_addr_q == OFS_CONTROL_REG_F) begin
            rd_val[F_CYCLE_BV_BIT] = per_bv_q;
            rd_val[F_CMP_BV_LSB +: NCH] = cmp_bv_q;
        end else if (dp_addr_q == OFS_EVENT_CONTROL) begin
            rd_val[EV_TICK_EN_BIT] = evt_en_q;
        end else if (dp_addr_q == OFS_CONTROL_REG_D) begin
            rd_val[D_SPLIT_BIT] = split_q;
        end else if (dp_addr_q == OFS_FLAGS) begin
            rd_val[FLAG_W-1:0] = flags_q;
            rd_val[8] = at_bottom;
            rd_val[9] = at_top;
            rd_val[10] = at_max;
        end else if (dp_addr_q == OFS_COUNT_VALUE) begin
            rd_val[CNT_W-1:0] = cnt_q;
        end else if (dp_addr_q == OFS_PERIOD) begin
            rd_val[CNT_W-1:0] = per_q;
        end else if (dp_addr_q == OFS_CYCLE_SHADOW) begin
            rd_val[CNT_W-1:0] = per_shadow_q;
        end else begin
            for (int i = 0; i < NCH; i++) begin
                if (dp_addr_q == OFS_COMPARE_BASE + 8'(i) * OFS_STRIDE) begin
                    rd_val[CNT_W-1:0] = cmp_q[i];
                end
                if (dp_addr_q == OFS_COMPARE_SHADOW + 8'(i) * OFS_STRIDE) begin
                    rd_val[CNT_W-1:0] = cmp_sh_q[i];
                end
            end
        end
    end

    // Control registers.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable_q     <= 1'b0;
            presc_q      <= 3'h0;
            dir_q        <= 1'b0;
            hold_q       <= 1'b0;
            upd_bottom_q <= 1'b0;
            evt_en_q     <= 1'b0;
            split_q      <= 1'b0;
        end else begin
            if (wr_a) begin
                enable_q <= hwdata[A_ENABLE_BIT];
                presc_q  <= hwdata[A_PRESCALE_LSB +: 3];
            end
            if (wr_e) begin
                dir_q        <= hwdata[E_DIR_BIT];
                hold_q       <= hwdata[E_HOLD_BIT];
                upd_bottom_q <= hwdata[E_UPD_BOTTOM_BIT];
            end
            if (wr_ev) begin
                evt_en_q <= hwdata[EV_TICK_EN_BIT];
            end
            if (wr_d) begin
                split_q <= hwdata[D_SPLIT_BIT];
            end
        end
    end

    tick_prescaler u_prescaler (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (enable_q && !evt_en_q),
        .select  (presc_q),
        .tick    (pre_tick)
    );

    // Software is expected to load the period before enabling.
    assign tick = enable_q && (evt_en_q ? event_in : pre_tick);

    assign at_bottom = (cnt_q == '0);
    assign at_top    = (cnt_q == per_q);
    assign at_max    = (cnt_q == {CNT_W{1'b1}});

    // UPDATE point follows the selected mode; split mode does not buffer.
    assign upd = tick && !split_q && !hold_q && (upd_bottom_q ? at_bottom : at_top);

    assign ovf_now    = tick && (split_q ? (cnt_q[HALF-1:0] == '0) : (dir_q ? at_bottom : at_top));
    assign ovf_hi_now = tick && split_q && (cnt_q[CNT_W-1:HALF] == '0);

    // Split halves both count down and reload from their own period byte.
    always_comb begin
        cnt_d = cnt_q;
        if (wr_cnt) begin
            cnt_d = hwdata[CNT_W-1:0];
        end else if (tick) begin
            if (split_q) begin
                cnt_d[HALF-1:0] = (cnt_q[HALF-1:0] == '0) ? per_q[HALF-1:0]
                                                         : cnt_q[HALF-1:0] - 1'b1;
                cnt_d[CNT_W-1:HALF] = (cnt_q[CNT_W-1:HALF] == '0) ? per_q[CNT_W-1:HALF]
                                                                 : cnt_q[CNT_W-1:HALF] - 1'b1;
            end else if (!dir_q) begin
                cnt_d = at_top ? '0 : cnt_q + 1'b1;
            end else begin
                cnt_d = at_bottom ? per_q : cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= RST_COUNT;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Period and its shadow; a shadow write sets the valid flag and beats the UPDATE clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            per_q        <= RST_PERIOD;
            per_shadow_q <= RST_PERIOD;
            per_bv_q     <= 1'b0;
        end else begin
            if (wr_per) begin
                per_q <= hwdata[CNT_W-1:0];
            end else if (upd && per_bv_q) begin
                per_q <= per_shadow_q;
            end
            if (wr_per_sh) begin
                per_shadow_q <= hwdata[CNT_W-1:0];
            end
            if (wr_per_sh) begin
                per_bv_q <= 1'b1;
            end else if (upd) begin
                per_bv_q <= 1'b0;
            end else if (wr_f) begin
                per_bv_q <= hwdata[F_CYCLE_BV_BIT];
            end
        end
    end

    for (genvar i = 0; i < NCH; i++) begin : g_channel
        assign wr_cmp[i]    = wr && (dp_addr_q == OFS_COMPARE_BASE + 8'(i) * OFS_STRIDE);
        assign wr_cmp_sh[i] = wr && (dp_addr_q == OFS_COMPARE_SHADOW + 8'(i) * OFS_STRIDE);

        assign match_lo[i] = split_q ? (cnt_q[HALF-1:0] == cmp_q[i][HALF-1:0])
                                     : (cnt_q == cmp_q[i]);
        assign match_hi[i] = split_q && (cnt_q[CNT_W-1:HALF] == cmp_q[i][CNT_W-1:HALF]);

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cmp_q[i]    <= RST_COMPARE;
                cmp_sh_q[i] <= RST_COMPARE;
                cmp_bv_q[i] <= 1'b0;
            end else begin
                if (wr_cmp[i]) begin
                    cmp_q[i] <= hwdata[CNT_W-1:0];
                end else if (upd && cmp_bv_q[i]) begin
                    cmp_q[i] <= cmp_sh_q[i];
                end
                if (wr_cmp_sh[i]) begin
                    cmp_sh_q[i] <= hwdata[CNT_W-1:0];
                end
                if (wr_cmp_sh[i]) begin
                    cmp_bv_q[i] <= 1'b1;
                end else if (upd) begin
                    cmp_bv_q[i] <= 1'b0;
                end else if (wr_f) begin
                    cmp_bv_q[i] <= hwdata[F_CMP_BV_LSB + i];
                end
            end
        end

        // Frequency style output: toggles on each match_lo compare trigger; split-mode high-byte triggers do not toggle it.
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                waveform_output[i] <= 1'b0;
            end else if (tick && match_lo[i]) begin
                waveform_output[i] <= !waveform_output[i];
            end
        end
    end

    // A condition reached earlier is acted on at the next tick.
    always_comb begin
        flag_set = '0;
        flag_set[FLAG_OVF]    = ovf_now;
        flag_set[FLAG_OVF_HI] = ovf_hi_now;
        flag_set[FLAG_CMP_LSB +: NCH]    = {NCH{tick}} & match_lo;
        flag_set[FLAG_CMP_HI_LSB +: NCH] = {NCH{tick}} & match_hi;
    end

    // Flags clear by writing ones; a set in the same cycle wins.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flags_q <= '0;
        end else begin
            flags_q <= (flags_q & ~(wr_flags ? hwdata[FLAG_W-1:0] : '0)) | flag_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_event    <= 1'b0;
            overflow_hi_event <= 1'b0;
            compare_event     <= '0;
            compare_hi_event  <= '0;
        end else begin
            overflow_event    <= ovf_now;
            overflow_hi_event <= ovf_hi_now;
            compare_event     <= {NCH{tick}} & match_lo;
            compare_hi_event  <= {NCH{tick}} & match_hi;
        end
    end

    AST_WRAP_UP: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !split_q && !dir_q && at_top && !wr_cnt |=> cnt_q == '0)
        else $error("Up count did not wrap to zero at top.");

    AST_RELOAD_DOWN: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !split_q && dir_q && at_bottom && !wr_cnt |=> cnt_q == $past(per_q))
        else $error("Down count did not reload the period at bottom.");

    AST_CNT_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cnt |=> cnt_q == $past(hwdata[CNT_W-1:0]))
        else $error("Counter write was not taken at once.");

    AST_HOLD_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        !enable_q && !wr_cnt |=> $stable(cnt_q) && !overflow_event && compare_event == '0)
        else $error("Disabled counter moved or triggered.");

    AST_UP_STEP: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && !split_q && !dir_q && !at_top && !wr_cnt |=> cnt_q == CNT_W'($past(cnt_q) + 1'b1))
        else $error("Up count did not step by one.");

    AST_PER_UPDATE: assert property (@(posedge hclk) disable iff (!hresetn)
        upd && per_bv_q && !wr_per && !wr_per_sh |=> per_q == $past(per_shadow_q) && !per_bv_q)
        else $error("Period shadow not moved at update.");

    AST_UPDATE_LOCK: assert property (@(posedge hclk) disable iff (!hresetn)
        hold_q && !wr_per |=> $stable(per_q))
        else $error("Period changed while update was held.");

    AST_BV_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_cmp_sh[0] |=> cmp_bv_q[0] ##0 cmp_sh_q[0] == $past(hwdata[CNT_W-1:0]))
        else $error("Compare shadow write did not set its valid flag.");

    AST_CMP_FLAG: assert property (@(posedge hclk) disable iff (!hresetn)
        tick && match_lo[0] |=> flags_q[FLAG_CMP_LSB] && compare_event[0])
        else $error("Compare match did not set flag and event.");

    AST_EVENT_SOURCE: assert property (@(posedge hclk) disable iff (!hresetn)
        enable_q && evt_en_q |-> tick == event_in)
        else $error("Event tick mode did not follow the event input.");

    AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        dp_valid_q && !dp_write_q && !rd_ready_q |-> !hreadyout ##1 hreadyout)
        else $error("Read did not complete after one wait state.");
endmodule : timer_type_a
`default_nettype wire

// >>> timer_type_a_pkg.sv
// Shared constants for the type A timer base counter: register map, fields, reset values and prescaler masks.
`default_nettype none
package timer_type_a_pkg;
    // Register byte offsets (one aligned word each).
    localparam logic [7:0] OFS_CONTROL_REG_A   = 8'h00;
    localparam logic [7:0] OFS_CONTROL_REG_E   = 8'h04;
    localparam logic [7:0] OFS_CONTROL_REG_F   = 8'h08;
    localparam logic [7:0] OFS_EVENT_CONTROL   = 8'h0c;
    localparam logic [7:0] OFS_CONTROL_REG_D   = 8'h10;
    localparam logic [7:0] OFS_FLAGS           = 8'h14;
    localparam logic [7:0] OFS_COUNT_VALUE     = 8'h20;
    localparam logic [7:0] OFS_PERIOD          = 8'h24;
    localparam logic [7:0] OFS_CYCLE_SHADOW    = 8'h28;
    localparam logic [7:0] OFS_COMPARE_BASE    = 8'h30;
    localparam logic [7:0] OFS_COMPARE_SHADOW  = 8'h40;
    localparam logic [7:0] OFS_STRIDE          = 8'h04;

    // Field positions in control_reg_a.
    localparam int A_ENABLE_BIT      = 0;
    localparam int A_PRESCALE_LSB    = 1;
    // Field positions in control_reg_e.
    localparam int E_DIR_BIT         = 0;
    localparam int E_HOLD_BIT        = 1;
    localparam int E_UPD_BOTTOM_BIT  = 2;
    // Field positions in control_reg_f.
    localparam int F_CYCLE_BV_BIT    = 0;
    localparam int F_CMP_BV_LSB      = 1;
    // Field positions in event_control_reg and control_reg_d.
    localparam int EV_TICK_EN_BIT    = 0;
    localparam int D_SPLIT_BIT       = 0;
    // Field positions in the flag register.
    localparam int FLAG_OVF          = 0;
    localparam int FLAG_OVF_HI       = 1;
    localparam int FLAG_CMP_LSB      = 2;
    localparam int FLAG_CMP_HI_LSB   = 5;
    localparam int FLAG_W            = 8;

    // Values after reset.
    localparam logic [15:0] RST_PERIOD  = 16'hffff;
    localparam logic [15:0] RST_COUNT   = 16'h0000;
    localparam logic [15:0] RST_COMPARE = 16'h0000;

    // Prescaler masks for divide by 1, 2, 4, 8, 16, 64, 256 and 1024.
    localparam int PRESCALE_W = 10;
    localparam logic [PRESCALE_W-1:0] PRESCALE_MASK [8] = '{
        10'h000, 10'h001, 10'h003, 10'h007, 10'h00f, 10'h03f, 10'h0ff, 10'h3ff
    };
endpackage : timer_type_a_pkg
`default_nettype wire
